// file: src/dsia_pkg.sv
// Notes on behaviour
// - three assembly formats: 70, 71, 101
// - 71 byte0: trip bit0, warning bit1
// - 71 byte0: forward bit2, reverse bit3
// - 71 ready bit4 when state 3-5
// - 71 bit5: run/stop from network
// - 71 bit6: reference from network
// - arrival flag: 71 bit7, 101 bit4
// - 101 byte0: fwd, rev, trip, bit3 unused
// - 101 eight bytes, frequency LSB first
// - 101 current in bytes 4, 5
// - 101 trip code byte6, byte7 unused
// - state code in byte1 of all
// - codes 0 stop, 1 run, 2 jog
// - code 3 stopped and coasting
// - code 4 during DC braking
// - restart matching: mode 03->5, 02->7
// - code 6 on power failure halt
// - code 8 waiting before restart
// - code 9 saving history; ignore reset
// - code 10 other trip condition
// - code 11 input under-voltage
package dsia_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL     = 8'h00;
    localparam logic [7:0] ADR_STATUS   = 8'h04;
    localparam logic [7:0] ADR_ASM_LO   = 8'h08;
    localparam logic [7:0] ADR_ASM_HI   = 8'h0C;
    localparam logic [7:0] ADR_LEN      = 8'h10;

    localparam int CTRL_SEL_LSB  = 0;
    localparam int CTRL_MODE_LSB = 8;
    localparam int STAT_CODE_LSB = 0;
    localparam int STAT_B0_LSB   = 8;
    localparam int STAT_BUSY_BIT = 16;

    // ----------------------------------------------------------------
    // assembly selection and lengths
    // ----------------------------------------------------------------
    localparam logic [7:0] ASM_BASIC = 8'h46;
    localparam logic [7:0] ASM_EXT   = 8'h47;
    localparam logic [7:0] ASM_FULL  = 8'h65;
    localparam logic [7:0] ASM_RESET = ASM_EXT;
    localparam logic [3:0] LEN_SHORT = 4'h4;
    localparam logic [3:0] LEN_LONG  = 4'h8;

    // restart mode setting values
    localparam logic [1:0] RMODE_02    = 2'h2;
    localparam logic [1:0] RMODE_03    = 2'h3;
    localparam logic [1:0] RMODE_RESET = 2'h0;

    // ----------------------------------------------------------------
    // status byte bit positions
    // ----------------------------------------------------------------
    localparam int B71_TRIP  = 0;
    localparam int B71_WARN  = 1;
    localparam int B71_FWD   = 2;
    localparam int B71_REV   = 3;
    localparam int B71_READY = 4;
    localparam int B71_NCTL  = 5;
    localparam int B71_NREF  = 6;
    localparam int B71_ARR   = 7;
    localparam int B70_TRIP  = 0;
    localparam int B70_FWD   = 2;
    localparam int B101_FWD  = 0;
    localparam int B101_REV  = 1;
    localparam int B101_TRIP = 2;
    localparam int B101_ARR  = 4;
    localparam int B101_TERM = 5;

    // ----------------------------------------------------------------
    // drive state codes
    // ----------------------------------------------------------------
    localparam logic [7:0] ST_STOP     = 8'h00;
    localparam logic [7:0] ST_RUN      = 8'h01;
    localparam logic [7:0] ST_JOG      = 8'h02;
    localparam logic [7:0] ST_COAST    = 8'h03;
    localparam logic [7:0] ST_DCBRAKE  = 8'h04;
    localparam logic [7:0] ST_MATCH03  = 8'h05;
    localparam logic [7:0] ST_PWRFAIL  = 8'h06;
    localparam logic [7:0] ST_MATCH02  = 8'h07;
    localparam logic [7:0] ST_RWAIT    = 8'h08;
    localparam logic [7:0] ST_TRIPSAVE = 8'h09;
    localparam logic [7:0] ST_TRIP     = 8'h0A;
    localparam logic [7:0] ST_UNDERV   = 8'h0B;

endpackage

// file: src/dsia_state_enc.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// drive state code encoder
// ----------------------------------------------------------------
module dsia_state_enc (
    input  wire logic       under_volt_i,
    input  wire logic       trip_saving_i,
    input  wire logic       trip_i,
    input  wire logic       pwr_fail_i,
    input  wire logic       restart_wait_i,
    input  wire logic       restart_match_i,
    input  wire logic [1:0] restart_mode_i,
    input  wire logic       dc_brake_i,
    input  wire logic       coast_i,
    input  wire logic       jog_i,
    input  wire logic       run_i,
    output logic      [7:0] code_o
);
    // priority: supply problems and trips mask any motion state
    always_comb
    begin
        if (under_volt_i)
            code_o = dsia_pkg::ST_UNDERV;
        else if (trip_saving_i)
            code_o = dsia_pkg::ST_TRIPSAVE;
        else if (trip_i)
            code_o = dsia_pkg::ST_TRIP;
        else if (pwr_fail_i)
            code_o = dsia_pkg::ST_PWRFAIL;
        else if (restart_wait_i)
            code_o = dsia_pkg::ST_RWAIT;
        else if (restart_match_i && restart_mode_i == dsia_pkg::RMODE_03)
            code_o = dsia_pkg::ST_MATCH03;
        else if (restart_match_i && restart_mode_i == dsia_pkg::RMODE_02)
            code_o = dsia_pkg::ST_MATCH02;
        else if (dc_brake_i)
            code_o = dsia_pkg::ST_DCBRAKE;
        else if (coast_i)
            code_o = dsia_pkg::ST_COAST;
        else if (jog_i)
            code_o = dsia_pkg::ST_JOG;
        else if (run_i)
            code_o = dsia_pkg::ST_RUN;
        else
            code_o = dsia_pkg::ST_STOP;
    end
endmodule

// file: src/dsia_top.sv
`timescale 1ns/1ps
module dsia_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // ----------------------------------------------------------------
    // wishbone slave
    // ----------------------------------------------------------------
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // ----------------------------------------------------------------
    // drive core status, same clock
    // ----------------------------------------------------------------
    input  wire logic        trip_i,
    input  wire logic        warning_i,
    input  wire logic        forward_running_flag_i,
    input  wire logic        reverse_running_flag_i,
    input  wire logic        jog_i,
    input  wire logic        coast_i,
    input  wire logic        dc_brake_i,
    input  wire logic        restart_match_i,
    input  wire logic        restart_wait_i,
    input  wire logic        pwr_fail_i,
    input  wire logic        trip_saving_i,
    input  wire logic        under_volt_i,
    input  wire logic        net_control_i,
    input  wire logic        net_reference_i,
    input  wire logic        at_target_i,
    input  wire logic        ramping_i,
    input  wire logic [15:0] freq_mon_i,
    input  wire logic [15:0] curr_mon_i,
    input  wire logic [7:0]  trip_code_i,
    input  wire logic        fault_reset_i,
    // input terminals from pins, asynchronous
    input  wire logic [2:0]  term_in_i,
    // ----------------------------------------------------------------
    // assembly byte stream toward the fieldbus engine
    // ----------------------------------------------------------------
    input  wire logic        frame_start_i,
    output logic             tx_valid_o,
    output logic      [7:0]  tx_data_o,
    output logic             tx_last_o,
    output logic             frame_busy_o,
    output logic             trip_reset_o
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic {
        DSIA_IDLE,
        DSIA_SEND
    } dsia_fsm_t;

    typedef struct packed {
        logic [7:0]      asm_sel;
        logic [1:0]      rmode;
        logic [2:0]      term_m;
        logic [2:0]      term_s;
        logic [7:0]      code;
        logic [7:0][7:0] live;
        logic [7:0][7:0] frame;
        logic [3:0]      len;
        dsia_fsm_t       fsm;
        logic [2:0]      idx;
        logic            tx_valid;
        logic [7:0]      tx_data;
        logic            tx_last;
        logic            ack;
        logic [31:0]     dat;
        logic            trip_reset;
    } dsia_state_t;

    dsia_state_t s_q;
    dsia_state_t s_d;
    logic [7:0]  code_w;

    dsia_state_enc u_enc (
        .under_volt_i    (under_volt_i),
        .trip_saving_i   (trip_saving_i),
        .trip_i          (trip_i),
        .pwr_fail_i      (pwr_fail_i),
        .restart_wait_i  (restart_wait_i),
        .restart_match_i (restart_match_i),
        .restart_mode_i  (s_q.rmode),
        .dc_brake_i      (dc_brake_i),
        .coast_i         (coast_i),
        .jog_i           (jog_i),
        .run_i           (forward_running_flag_i | reverse_running_flag_i),
        .code_o          (code_w)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic valid_sel(input logic [7:0] sel);
        valid_sel = (sel == dsia_pkg::ASM_BASIC) || (sel == dsia_pkg::ASM_EXT) || (sel == dsia_pkg::ASM_FULL);
    endfunction

    function automatic logic [3:0] asm_len(input logic [7:0] sel);
        asm_len = (sel == dsia_pkg::ASM_FULL) ? dsia_pkg::LEN_LONG : dsia_pkg::LEN_SHORT;
    endfunction

    function automatic logic [31:0] pack_word(input logic [7:0][7:0] b, input logic hi);
        pack_word = hi ? {b[7], b[6], b[5], b[4]} : {b[3], b[2], b[1], b[0]};
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic        motion;
    logic        arrived;
    logic        ready;
    logic [7:0]  b0;
    logic        wb_req;

    always_comb
    begin
        s_d = s_q;

        // terminals are pins, so they pass two flops before use
        s_d.term_m = term_in_i;
        s_d.term_s = s_q.term_m;
        s_d.code   = code_w;

        motion  = forward_running_flag_i | reverse_running_flag_i;
        // a stopped or ramping drive never reports arrival
        arrived = at_target_i & motion & ~ramping_i;
        ready   = (s_q.code == dsia_pkg::ST_COAST) || (s_q.code == dsia_pkg::ST_DCBRAKE)
                  || (s_q.code == dsia_pkg::ST_MATCH03);

        b0 = 8'h00;
        unique case (s_q.asm_sel)
            dsia_pkg::ASM_FULL:
            begin
                b0[dsia_pkg::B101_FWD]  = forward_running_flag_i;
                b0[dsia_pkg::B101_REV]  = reverse_running_flag_i;
                b0[dsia_pkg::B101_TRIP] = trip_i;
                b0[dsia_pkg::B101_ARR]  = arrived;
                b0[dsia_pkg::B101_TERM +: 3] = s_q.term_s;
            end
            dsia_pkg::ASM_BASIC:
            begin
                b0[dsia_pkg::B70_TRIP] = trip_i;
                b0[dsia_pkg::B70_FWD]  = forward_running_flag_i;
            end
            default:
            begin
                b0[dsia_pkg::B71_TRIP]  = trip_i;
                b0[dsia_pkg::B71_WARN]  = warning_i;
                b0[dsia_pkg::B71_FWD]   = forward_running_flag_i;
                b0[dsia_pkg::B71_REV]   = reverse_running_flag_i;
                b0[dsia_pkg::B71_READY] = ready;
                b0[dsia_pkg::B71_NCTL]  = net_control_i;
                b0[dsia_pkg::B71_NREF]  = net_reference_i;
                b0[dsia_pkg::B71_ARR]   = arrived;
            end
        endcase

        s_d.live[0] = b0;
        s_d.live[1] = s_q.code;
        s_d.live[2] = freq_mon_i[7:0];
        s_d.live[3] = freq_mon_i[15:8];
        s_d.live[4] = 8'h00;
        s_d.live[5] = 8'h00;
        s_d.live[6] = 8'h00;
        s_d.live[7] = 8'h00;
        if (s_q.asm_sel == dsia_pkg::ASM_FULL)
        begin
            s_d.live[4] = curr_mon_i[7:0];
            s_d.live[5] = curr_mon_i[15:8];
            s_d.live[6] = trip_code_i;
        end
        s_d.len = asm_len(s_q.asm_sel);

        // a clear request during history saving is dropped, not held
        s_d.trip_reset = fault_reset_i && (s_q.code != dsia_pkg::ST_TRIPSAVE);

        // ------------------------------------------------------------
        // framer: snapshot keeps a frame coherent while it streams
        // ------------------------------------------------------------
        s_d.tx_valid = 1'b0;
        s_d.tx_last  = 1'b0;
        unique case (s_q.fsm)
            DSIA_IDLE:
            begin
                if (frame_start_i)
                begin
                    s_d.frame = s_q.live;
                    s_d.idx   = 3'h0;
                    s_d.fsm   = DSIA_SEND;
                end
            end
            DSIA_SEND:
            begin
                s_d.tx_valid = 1'b1;
                s_d.tx_data  = s_q.frame[s_q.idx];
                s_d.idx      = s_q.idx + 3'h1;
                if ({1'b0, s_q.idx} == s_q.len - 4'h1)
                begin
                    s_d.tx_last = 1'b1;
                    s_d.fsm     = DSIA_IDLE;
                end
            end
        endcase

        // ------------------------------------------------------------
        // wishbone: one wait state, unmapped reads return zero
        // ------------------------------------------------------------
        wb_req  = wb_cyc_i & wb_stb_i & ~s_q.ack;
        s_d.ack = wb_req;
        s_d.dat = 32'h0000_0000;
        if (wb_req)
        begin
            unique case (wb_adr_i)
                dsia_pkg::ADR_CTRL:
                begin
                    s_d.dat[dsia_pkg::CTRL_SEL_LSB +: 8]  = s_q.asm_sel;
                    s_d.dat[dsia_pkg::CTRL_MODE_LSB +: 2] = s_q.rmode;
                    // format only changes to a documented value
                    if (wb_we_i && wb_sel_i[0] && valid_sel(wb_dat_i[dsia_pkg::CTRL_SEL_LSB +: 8]))
                        s_d.asm_sel = wb_dat_i[dsia_pkg::CTRL_SEL_LSB +: 8];
                    if (wb_we_i && wb_sel_i[1])
                        s_d.rmode = wb_dat_i[dsia_pkg::CTRL_MODE_LSB +: 2];
                end
                dsia_pkg::ADR_STATUS:
                begin
                    s_d.dat[dsia_pkg::STAT_CODE_LSB +: 8] = s_q.live[1];
                    s_d.dat[dsia_pkg::STAT_B0_LSB +: 8]   = s_q.live[0];
                    s_d.dat[dsia_pkg::STAT_BUSY_BIT]      = (s_q.fsm == DSIA_SEND);
                end
                dsia_pkg::ADR_ASM_LO:
                    s_d.dat = pack_word(s_q.live, 1'b0);
                dsia_pkg::ADR_ASM_HI:
                    s_d.dat = pack_word(s_q.live, 1'b1);
                dsia_pkg::ADR_LEN:
                    s_d.dat[3:0] = s_q.len;
                default:
                    s_d.dat = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q            <= '0;
            s_q.asm_sel    <= dsia_pkg::ASM_RESET;
            s_q.rmode      <= dsia_pkg::RMODE_RESET;
            s_q.len        <= dsia_pkg::LEN_SHORT;
            s_q.fsm        <= DSIA_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o     = s_q.dat;
    assign wb_ack_o     = s_q.ack;
    assign tx_valid_o   = s_q.tx_valid;
    assign tx_data_o    = s_q.tx_data;
    assign tx_last_o    = s_q.tx_last;
    // the busy flop is the fsm state itself
    assign frame_busy_o = (s_q.fsm == DSIA_SEND);
    assign trip_reset_o = s_q.trip_reset;

endmodule

// file: testbench/dsia_checker.sv
`timescale 1ns/1ps
module dsia_checker (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic        trip_saving_i,
    input  wire logic        under_volt_i,
    input  wire logic        fault_reset_i,
    input  wire logic        frame_start_i,
    input  wire logic        tx_valid_o,
    input  wire logic        tx_last_o,
    input  wire logic        frame_busy_o,
    input  wire logic        trip_reset_o
);
    // ----------------------------------------------------------------
    // bus answers
    // ----------------------------------------------------------------
    a_ack_answers: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("request not acknowledged");
    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_dat_idle_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data without ack");
    // ----------------------------------------------------------------
    // frame stream
    // ----------------------------------------------------------------
    a_start_taken: assert property (@(posedge clk_i) disable iff (rst_i)
        (frame_start_i && !frame_busy_o && !tx_valid_o) |=> frame_busy_o) else $error("start not taken");
    a_busy_to_data: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(frame_busy_o) |=> tx_valid_o) else $error("first byte late");
    a_frame_min_len: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(tx_valid_o) |-> tx_valid_o [*4]) else $error("frame shorter than four bytes");
    a_frame_max_len: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(tx_valid_o) |-> ##[3:7] tx_last_o) else $error("frame without last byte");
    a_last_ends_frame: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_last_o |-> tx_valid_o ##1 !tx_valid_o) else $error("bytes after last");
    // ----------------------------------------------------------------
    // trip clearing
    // ----------------------------------------------------------------
    a_trip_clr_src: assert property (@(posedge clk_i) disable iff (rst_i)
        trip_reset_o |-> $past(fault_reset_i)) else $error("trip clear without request");
    a_trip_clr_block: assert property (@(posedge clk_i) disable iff (rst_i)
        (trip_saving_i && !under_volt_i) [*4] |-> !trip_reset_o) else $error("trip cleared while saving");
endmodule

bind dsia_top dsia_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trip_saving_i(trip_saving_i), .under_volt_i(under_volt_i),
    .fault_reset_i(fault_reset_i), .frame_start_i(frame_start_i), .tx_valid_o(tx_valid_o),
    .tx_last_o(tx_last_o), .frame_busy_o(frame_busy_o), .trip_reset_o(trip_reset_o));

// file: testbench/dsia_host_model.sv
`timescale 1ns/1ps
// polling host: one start pulse, then bytes are collected until the last flag
module dsia_host_model (
    input  wire logic       clk_i,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_last_i,
    output logic            frame_start_o
);
    logic [7:0] rx [8];
    int         n;
    initial frame_start_o = 1'b0;
    // only called while idle; a start during a frame would be dropped
    task automatic poll();
        n = 0;
        frame_start_o <= 1'b1;
        @(posedge clk_i);
        frame_start_o <= 1'b0;
        repeat (16)
        begin
            @(posedge clk_i);
            if (tx_valid_i && n < 8)
            begin
                rx[n] = tx_data_i;
                n++;
            end
            if (tx_valid_i && tx_last_i)
                break;
        end
    endtask
endmodule

// file: testbench/dsia_top_tb.sv
`timescale 1ns/1ps
module dsia_top_tb;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, fres = 1'b0;
    logic [7:0]  adr = 8'h00, tcode = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [3:0]  sel = 4'h0;
    logic [15:0] dv = 16'h0, fm = 16'h0, cm = 16'h0;
    logic [2:0]  term = 3'h0;
    logic        ack, start, tvalid, tlast, busy, trst;
    logic [7:0]  tdata;
    int          errors = 0, total_checks = 0, cycles = 0;
    // dv: uv, save, trip, pwrfail, rwait, rmatch, dcbrake, coast, jog, rev, fwd, warn, nctl, nref, arrive, ramp
    // packed so that index 0 is the rightmost entry; a packed table also suits simple simulators
    localparam logic [11:0][31:0] CASES = {32'h2010_0A03, 32'h6000_0901, 32'h0800_0800, 32'h1000_0600,
        32'h0400_0510, 32'h0200_0410, 32'h0100_0310, 32'h0080_0200, 32'h0043_0108, 32'h002E_01E4,
        32'h0020_0104, 32'h0000_0000};

    always #5 clk_i = ~clk_i;

    dsia_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .under_volt_i(dv[15]),
        .trip_saving_i(dv[14]), .trip_i(dv[13]), .pwr_fail_i(dv[12]), .restart_wait_i(dv[11]),
        .restart_match_i(dv[10]), .dc_brake_i(dv[9]), .coast_i(dv[8]), .jog_i(dv[7]),
        .reverse_running_flag_i(dv[6]), .forward_running_flag_i(dv[5]), .warning_i(dv[4]),
        .net_control_i(dv[3]), .net_reference_i(dv[2]), .at_target_i(dv[1]), .ramping_i(dv[0]),
        .freq_mon_i(fm), .curr_mon_i(cm), .trip_code_i(tcode), .fault_reset_i(fres), .term_in_i(term),
        .frame_start_i(start), .tx_valid_o(tvalid), .tx_data_o(tdata), .tx_last_o(tlast),
        .frame_busy_o(busy), .trip_reset_o(trst));

    dsia_host_model host (.clk_i(clk_i), .tx_valid_i(tvalid), .tx_data_i(tdata), .tx_last_i(tlast),
        .frame_start_o(start));

    // ----------------------------------------------------------------
    // checking and bus tasks
    // ----------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // classic cycle: hold everything until ack is sampled, then release for one cycle
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        forever
        begin
            @(posedge clk_i);
            if (ack === 1'b1)
                break;
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, 4'hF);
        chk(q, exp);
    endtask

    task automatic settle(input logic [15:0] v);
        dv <= v;
        repeat (4) @(posedge clk_i);
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(dsia_pkg::ADR_CTRL, 32'h0000_0047);
        rd(dsia_pkg::ADR_LEN, 32'h4);
        rd(8'h20, 32'h0);
        xfer(1'b1, dsia_pkg::ADR_CTRL, 32'h0000_0347, 4'h3);
        for (int i = 0; i < 12; i++)
        begin
            settle(CASES[i][31:16]);
            rd(dsia_pkg::ADR_STATUS, {16'h0, CASES[i][7:0], CASES[i][15:8]});
        end
        settle(16'hA000);
        rd(dsia_pkg::ADR_STATUS, 32'h0000_010B);
        xfer(1'b1, dsia_pkg::ADR_CTRL, 32'h0000_0247, 4'h3);
        settle(16'h0400);
        rd(dsia_pkg::ADR_STATUS, 32'h0000_0007);
        // fault clearing is swallowed while history is saved
        fres <= 1'b1;
        settle(16'h6000);
        chk({31'h0, trst}, 32'h0);
        settle(16'h2000);
        chk({31'h0, trst}, 32'h1);
        fres <= 1'b0;
        // ----------------------------------------------------------------
        // frames
        // ----------------------------------------------------------------
        fm <= 16'h1234;
        cm <= 16'hABCD;
        tcode <= 8'h5A;
        term <= 3'b101;
        xfer(1'b1, dsia_pkg::ADR_CTRL, 32'h0000_0065, 4'h1);
        settle(16'h0022);
        rd(dsia_pkg::ADR_LEN, 32'h8);
        rd(dsia_pkg::ADR_ASM_LO, 32'h1234_01B1);
        rd(dsia_pkg::ADR_ASM_HI, 32'h005A_ABCD);
        host.poll();
        chk({host.rx[3], host.rx[2], host.rx[1], host.rx[0]}, 32'h1234_01B1);
        chk({host.rx[7], host.rx[6], host.rx[5], host.rx[4]}, 32'h005A_ABCD);
        chk(host.n, 8);
        settle(16'h2000);
        rd(dsia_pkg::ADR_STATUS, 32'h0000_A40A);
        xfer(1'b1, dsia_pkg::ADR_CTRL, 32'h0000_0046, 4'h1);
        xfer(1'b1, dsia_pkg::ADR_CTRL, 32'h0000_0050, 4'h1);
        rd(dsia_pkg::ADR_CTRL, 32'h0000_0246);
        host.poll();
        chk({host.rx[3], host.rx[2], host.rx[1], host.rx[0]}, 32'h1234_0A01);
        chk(host.n, 4);
        // a second reset must bring back the power-on format and restart mode
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(dsia_pkg::ADR_CTRL, 32'h0000_0047);
        rd(dsia_pkg::ADR_LEN, 32'h4);
        // matching restart with mode 0 has no code of its own and falls to run
        settle(16'h0420);
        rd(dsia_pkg::ADR_STATUS, 32'h0000_0401);
        end_sim();
    end
endmodule
